// ---- rtl/dsf_pkg.sv ----
/*
 * package for the device status flag bank: offsets, bit positions, reset values, timing.
 * assumes a 20 MHz device clock.
 */
package dsf_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] DSF_OFS_MAIN   = 8'h01;
    localparam logic [7:0] DSF_OFS_SUPPLY = 8'h02;
    localparam logic [7:0] DSF_OFS_MEM    = 8'h03;

    // ****************************************
    // bit positions
    // ****************************************
    localparam int DSF_B_INIT    = 0;
    localparam int DSF_B_RESET   = 1;
    localparam int DSF_B_SUP_ANY = 3;
    localparam int DSF_B_MEM_ANY = 4;
    localparam int DSF_B_EDGE    = 0;
    localparam int DSF_B_OTPREG  = 1;
    localparam int DSF_B_DIGREG  = 2;
    localparam int DSF_B_ANAREG  = 3;
    localparam int DSF_B_UV      = 7;
    localparam int DSF_B_TEMP    = 2;
    localparam int DSF_B_WACT    = 4;
    localparam int DSF_B_URW     = 5;
    localparam int DSF_B_UOTP    = 6;
    localparam int DSF_B_FOTP    = 7;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [1:0] DSF_MAIN_RST = 2'h3;
    localparam logic [4:0] DSF_SUP_RST  = 5'h00;
    localparam logic [3:0] DSF_MEM_RST  = 4'h0;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ          = 20_000_000;
    localparam int SUP_RCV_US      = 10;
    localparam int SUP_RCV_CYC     = (SUP_RCV_US * (CLK_HZ / 1_000_000));
    localparam int DSF_TMR_W       = 16;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic vcc_uv;
        logic ana_reg;
        logic dig_reg;
        logic otp_reg;
        logic edge_break;
    } dsf_supply_t;

    typedef struct packed {
        logic factory_otp;
        logic user_otp;
        logic temp_range;
    } dsf_memfault_t;

endpackage

// ---- rtl/dsf_rcv_timer.sv ----
/*
 * shared supply recovery timer; reloads while any supply fault exists.
 * assumes one clock, synchronous active-low reset.
 */
`timescale 1ns/10ps
module dsf_rcv_timer
    import dsf_pkg::*;
(
    input  wire logic clk_i,    // device clock
    input  wire logic rst_n_i,  // sync reset, low
    input  wire logic fault_i,  // any supply fault present
    output logic      zero_o    // timer at zero
);

    logic [DSF_TMR_W-1:0] cnt_ff;
    logic [DSF_TMR_W-1:0] nxt_cnt;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (fault_i) begin
            nxt_cnt = DSF_TMR_W'(SUP_RCV_CYC);
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_ff <= DSF_TMR_W'(SUP_RCV_CYC);
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign zero_o = (cnt_ff == '0);

    chk_timer_reload : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        fault_i |=> !zero_o) else $error("timer not reloaded on fault");

endmodule

// ---- rtl/dsf_status_bank.sv ----
/*
 * device status flag bank: main, supply and memory/temperature status registers.
 * assumes synchronous fault inputs, one-cycle read strobes from the serial interface.
 */
// Behaviour
// - reset-occurred flag, main bit 1, is set after every reset.
// - reset flag clears on main register read or status report of it.
// - init flag bit 0 set at reset, clears when data first valid.
// - one shared recovery timer reloads while any supply fault present.
// - supply flags clear according to the report-disable setting.
// - reporting enabled: read or report clears supply flags only at timer zero.
// - reporting disabled: supply flags clear by themselves at timer zero.
// - supply bit 7 set while main supply below undervoltage threshold.
// - supply bits 3,2,1 set on analog, digital, OTP regulator faults.
// - supply bit 0 set on edge-seal continuity break.
// - memory bit 7 set on factory OTP fault.
// - memory bit 6 set on user OTP fault.
// - after init lock, check code mismatch sets memory bit 5.
// - memory bits 7,6,5,2 clear on read or status report.
// - memory bit 4 follows user OTP write in progress.
// - memory bit 2 set on over or undertemperature.
`timescale 1ns/10ps
module dsf_status_bank
    import dsf_pkg::*;
(
    input  wire logic          clk_i,          // device clock
    input  wire logic          rst_n_i,        // sync reset, low
    input  wire logic [7:0]    rd_addr_i,      // register read address
    input  wire logic          rd_en_i,        // read strobe, one cycle
    input  wire logic          wr_en_i,        // write strobe, ignored here
    input  wire logic          data_valid_i,   // sensor data valid
    input  wire logic          rpt_main_i,     // status field reported reset flag
    input  wire logic          rpt_supply_i,   // status field reported supply error
    input  wire logic          rpt_mem_i,      // status field reported memory error
    input  wire dsf_supply_t   supply_i,       // supply fault levels
    input  wire dsf_memfault_t memfault_i,     // memory/temp fault levels
    input  wire logic          otp_wr_busy_i,  // user OTP write in progress
    input  wire logic          init_lock_i,    // init complete lock
    input  wire logic          supply_rpt_dis_i, // supply report disable
    input  wire logic [3:0]    crc_calc_i,     // recomputed check code
    input  wire logic [3:0]    crc_stored_i,   // stored check code
    output logic [7:0]         rd_data_o,      // read data, registered
    output logic [7:0]         main_status_o,  // main status image
    output logic [7:0]         supply_status_o, // supply status image
    output logic [7:0]         mem_status_o    // memory status image
);

    // ****************************************
    // state
    // ****************************************
    logic [1:0]    main_ff;
    logic [1:0]    nxt_main;
    dsf_supply_t   sup_ff;
    dsf_supply_t   nxt_sup;
    logic [3:0]    mem_ff;   // fotp, uotp, urw, temp
    logic [3:0]    nxt_mem;
    logic          wact_ff;
    logic          nxt_wact;
    logic [7:0]    rd_ff;
    logic [7:0]    nxt_rd;
    logic          tmr_zero;
    logic          sup_fault;
    logic          rd_main;
    logic          rd_sup;
    logic          rd_mem;
    logic          urw_fault;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return rd_en_i && (a == ofs);
    endfunction

    assign rd_main   = hit(rd_addr_i, DSF_OFS_MAIN);
    assign rd_sup    = hit(rd_addr_i, DSF_OFS_SUPPLY);
    assign rd_mem    = hit(rd_addr_i, DSF_OFS_MEM);
    assign sup_fault = |supply_i;
    assign urw_fault = init_lock_i && (crc_calc_i != crc_stored_i);

    dsf_rcv_timer u_tmr (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .fault_i (sup_fault),
        .zero_o  (tmr_zero)
    );

    // ****************************************
    // flag next state
    // ****************************************
    always_comb begin
        nxt_main = main_ff;
        if (rd_main || rpt_main_i) begin
            nxt_main[DSF_B_RESET] = 1'b0;
        end
        if (data_valid_i) begin
            nxt_main[DSF_B_INIT] = 1'b0;
        end

        nxt_sup = sup_ff;
        if (supply_rpt_dis_i) begin
            if (tmr_zero) begin
                nxt_sup = '0;
            end
        end else if ((rd_sup || rpt_supply_i) && tmr_zero) begin
            nxt_sup = '0;
        end
        nxt_sup = nxt_sup | supply_i;

        nxt_mem = mem_ff;
        if (rd_mem || rpt_mem_i) begin
            nxt_mem = '0;
        end
        nxt_mem = nxt_mem | {memfault_i.factory_otp, memfault_i.user_otp,
                             urw_fault, memfault_i.temp_range};
        nxt_wact = otp_wr_busy_i;
    end

    // ****************************************
    // read mux
    // ****************************************
    always_comb begin
        nxt_rd = rd_ff;
        if (rd_main) begin
            nxt_rd = main_status_o;
        end else if (rd_sup) begin
            nxt_rd = supply_status_o;
        end else if (rd_mem) begin
            nxt_rd = mem_status_o;
        end else if (rd_en_i) begin
            nxt_rd = 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            main_ff <= DSF_MAIN_RST;
            sup_ff  <= DSF_SUP_RST;
            mem_ff  <= DSF_MEM_RST;
            wact_ff <= 1'b0;
            rd_ff   <= 8'h00;
        end else begin
            main_ff <= nxt_main;
            sup_ff  <= nxt_sup;
            mem_ff  <= nxt_mem;
            wact_ff <= nxt_wact;
            rd_ff   <= nxt_rd;
        end
    end

    // ****************************************
    // register images, reserved bits zero
    // ****************************************
    always_comb begin
        main_status_o = 8'h00;
        main_status_o[DSF_B_INIT]    = main_ff[DSF_B_INIT];
        main_status_o[DSF_B_RESET]   = main_ff[DSF_B_RESET];
        main_status_o[DSF_B_SUP_ANY] = |sup_ff;
        main_status_o[DSF_B_MEM_ANY] = (|mem_ff) | wact_ff;
        supply_status_o = 8'h00;
        supply_status_o[DSF_B_UV]     = sup_ff.vcc_uv;
        supply_status_o[DSF_B_ANAREG] = sup_ff.ana_reg;
        supply_status_o[DSF_B_DIGREG] = sup_ff.dig_reg;
        supply_status_o[DSF_B_OTPREG] = sup_ff.otp_reg;
        supply_status_o[DSF_B_EDGE]   = sup_ff.edge_break;
        mem_status_o = 8'h00;
        mem_status_o[DSF_B_FOTP] = mem_ff[3];
        mem_status_o[DSF_B_UOTP] = mem_ff[2];
        mem_status_o[DSF_B_URW]  = mem_ff[1];
        mem_status_o[DSF_B_TEMP] = mem_ff[0];
        mem_status_o[DSF_B_WACT] = wact_ff;
    end

    assign rd_data_o = rd_ff; // wr_en_i has no effect

    // ****************************************
    // checks
    // ****************************************
    chk_reset_set : assert property (@(posedge clk_i)
        !rst_n_i |=> (main_ff == DSF_MAIN_RST)) else $error("reset flags not set");
    chk_reset_flag_clear : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_main |=> !main_ff[DSF_B_RESET]) else $error("reset flag not cleared");
    chk_rpt_main_clear : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rpt_main_i |=> !main_ff[DSF_B_RESET]) else $error("reset flag kept on report");
    chk_init_clear : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        data_valid_i |=> !main_ff[DSF_B_INIT]) else $error("init flag stuck");
    chk_supply_hold : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!tmr_zero && (|sup_ff)) |=> (|sup_ff)) else $error("supply cleared early");
    chk_supply_auto : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (supply_rpt_dis_i && tmr_zero && !sup_fault) |=> (sup_ff == '0))
        else $error("supply not auto cleared");
    chk_supply_set : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        supply_i.vcc_uv |=> supply_status_o[DSF_B_UV]) else $error("uv flag missing");
    chk_ana_set : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        supply_i.ana_reg |=> supply_status_o[DSF_B_ANAREG]) else $error("ana flag missing");
    chk_dig_set : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        supply_i.dig_reg |=> supply_status_o[DSF_B_DIGREG]) else $error("dig flag missing");
    chk_otpreg_set : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        supply_i.otp_reg |=> supply_status_o[DSF_B_OTPREG]) else $error("otp reg flag missing");
    chk_edge_set : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        supply_i.edge_break |=> supply_status_o[DSF_B_EDGE]) else $error("edge flag missing");
    chk_fotp_set : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        memfault_i.factory_otp |=> mem_status_o[DSF_B_FOTP]) else $error("fotp flag missing");
    chk_uotp_set : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        memfault_i.user_otp |=> mem_status_o[DSF_B_UOTP]) else $error("uotp flag missing");
    chk_urw_set : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        urw_fault |=> mem_status_o[DSF_B_URW]) else $error("check mismatch lost");
    chk_mem_clear : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rd_mem && memfault_i == '0 && !urw_fault) |=> (mem_ff == '0))
        else $error("memory flags not cleared");
    chk_mem_rpt_clear : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rpt_mem_i && memfault_i == '0 && !urw_fault) |=> (mem_ff == '0))
        else $error("memory flags kept on report");
    chk_mem_rd_value : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_mem |=> (rd_data_o == $past(mem_status_o))) else $error("read value wrong");
    chk_wact_track : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        otp_wr_busy_i |=> mem_status_o[DSF_B_WACT]) else $error("wact missing");
    chk_wact_clear : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !otp_wr_busy_i |=> !mem_status_o[DSF_B_WACT]) else $error("wact stuck");
    chk_temp_mark : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        memfault_i.temp_range |=> mem_status_o[DSF_B_TEMP]) else $error("temp flag missing");
    chk_temp_set : assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (memfault_i.temp_range && rd_mem) |=> mem_status_o[DSF_B_TEMP])
        else $error("temp fault lost on clear");

endmodule

// ---- tb/dsf_host_model.sv ----
/*
 * host model: reads one status register per one-cycle strobe.
 * assumes inputs are driven at the falling clock edge.
 */
`timescale 1ns/10ps
module dsf_host_model
    import dsf_pkg::*;
(
    input  wire logic       clk_i,     // device clock
    input  wire logic       init_i,    // init flag image
    input  wire logic [7:0] rd_data_i, // read data
    output logic            rd_en_o,   // read strobe
    output logic [7:0]      rd_addr_o  // read address
);
    // ****
    // read cycle
    // ****
    initial begin
        rd_en_o   = 1'b0;
        rd_addr_o = 8'h00;
    end
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        while (a == DSF_OFS_SUPPLY && init_i)
            @(negedge clk_i);
        @(negedge clk_i);
        rd_en_o   <= 1'b1;
        rd_addr_o <= a;
        @(negedge clk_i);
        rd_en_o   <= 1'b0;
        rd_addr_o <= ~a;
        d = rd_data_i;
    endtask
endmodule

// ---- tb/dsf_status_bank_tb_top.sv ----
/*
 * testbench: integer flag model compared with the bank at every read.
 * assumes the host model and the package.
 */
`timescale 1ns/10ps
module dsf_status_bank_tb_top
    import dsf_pkg::*;
;
    // ****
    // stimulus and instances
    // ****
    localparam int TMO = 4000;
    logic          clk, rst_n, rd_en, wr_en, dval, busy, lock, dis;
    logic [7:0]    addr, rdata, main_o, sup_o, mem_o;
    logic [2:0]    rpt;
    logic [3:0]    crc_c, crc_s;
    logic [31:0]   lf;
    dsf_supply_t   sv;
    dsf_memfault_t mv;
    int            error_cnt, tests_run, cyc, tmr, m_init, m_rst, m_sup, m_mem, p_sup, p_mem;

    dsf_status_bank dsf_status_bank_inst (.clk_i(clk), .rst_n_i(rst_n), .rd_addr_i(addr),
        .rd_en_i(rd_en), .wr_en_i(wr_en), .data_valid_i(dval), .rpt_main_i(rpt[0]),
        .rpt_supply_i(rpt[1]), .rpt_mem_i(rpt[2]), .supply_i(sv), .memfault_i(mv),
        .otp_wr_busy_i(busy), .init_lock_i(lock), .supply_rpt_dis_i(dis), .crc_calc_i(crc_c),
        .crc_stored_i(crc_s), .rd_data_o(rdata), .main_status_o(main_o),
        .supply_status_o(sup_o), .mem_status_o(mem_o));
    dsf_host_model dsf_host_model_inst (.clk_i(clk), .init_i(main_o[0]), .rd_data_i(rdata),
        .rd_en_o(rd_en), .rd_addr_o(addr));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (!rst_n || sv != 5'h00) tmr <= SUP_RCV_CYC;
        else if (tmr > 0) tmr <= tmr - 1;
        if (cyc == TMO) begin
            error_cnt++;
            complete_run();
        end
    end

    // ****
    // model and checks
    // ****
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [7:0] expv(input logic [7:0] a);
        if (a == DSF_OFS_MAIN) return {3'h0, m_mem != 0, m_sup != 0, 1'b0, m_rst[0], m_init[0]};
        if (a == DSF_OFS_SUPPLY) return m_sup[7:0];
        if (a == DSF_OFS_MEM) return m_mem[7:0];
        return 8'h00;
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic rdc(input logic [7:0] a);
        logic [7:0] d;
        if (dis && tmr == 0) m_sup = p_sup;
        @(negedge clk);
        if (a != 8'h00)
            chk("image", expv(a), a == 8'h01 ? main_o : a == 8'h02 ? sup_o : mem_o);
        dsf_host_model_inst.rd(a, d);
        chk($sformatf("read %h", a), expv(a), d);
        if (a == DSF_OFS_MAIN) m_rst = 0;
        if (a == DSF_OFS_SUPPLY && !dis && tmr == 0) m_sup = p_sup;
        if (a == DSF_OFS_MEM) m_mem = p_mem;
    endtask
    task automatic drv(input logic [4:0] s, input logic [2:0] m, input logic b, input logic bad);
        @(negedge clk);
        sv = s;
        mv = m;
        busy = b;
        lf = lfsr(lf);
        wr_en = lf[7];
        crc_c = lf[3:0];
        crc_s = lf[3:0] ^ {3'h0, bad};
        p_sup = {s[4], 3'h0, s[3:0]};
        p_mem = {m[2:1], 1'b0, b, 1'b0, m[0], 2'h0};
        m_sup |= p_sup;
        m_mem = (m_mem & 8'hef) | p_mem | ((bad & lock) << 5);
    endtask
    task automatic rpt_pulse(input int k);
        @(negedge clk);
        rpt[k] = 1'b1;
        @(negedge clk);
        rpt = 3'h0;
        if (k == 0) m_rst = 0;
        if (k == 1 && !dis && tmr == 0) m_sup = p_sup;
        if (k == 2) m_mem = p_mem;
    endtask
    task automatic do_reset();
        @(negedge clk);
        rst_n = 1'b0;
        lock = 1'b0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        {m_init, m_rst, m_sup, m_mem} = {32'd1, 32'd1, 32'd0, 32'd0};
    endtask

    // ****
    // scenarios
    // ****
    initial begin
        {rst_n, wr_en, dval, busy, lock, dis, rpt, crc_c, crc_s} = '0;
        {sv, mv, error_cnt, tests_run, cyc, p_sup, p_mem} = '0;
        lf = 32'h0000_6c58;
        do_reset();
        rdc(DSF_OFS_MAIN);
        rdc(DSF_OFS_MAIN);
        rdc(8'h00);
        @(negedge clk);
        dval = 1'b1;
        @(negedge clk);
        dval = 1'b0;
        m_init = 0;
        rdc(DSF_OFS_MAIN);
        for (int i = 0; i < 4; i++) begin
            lock = (i > 1);
            drv(5'h00, i == 0 ? 3'h7 : lf[6:4], 1'b0, 1'b1);
            drv(5'h00, 3'h0, 1'b0, 1'b0);
            rdc(DSF_OFS_MAIN);
            if (i == 3) rpt_pulse(2);
            rdc(DSF_OFS_MEM);
            rdc(DSF_OFS_MEM);
        end
        drv(5'h00, 3'h1, 1'b1, 1'b0);
        rdc(DSF_OFS_MEM);
        rdc(DSF_OFS_MEM);
        drv(5'h00, 3'h0, 1'b0, 1'b0);
        rdc(DSF_OFS_MEM);
        for (int i = 0; i < 6; i++) begin
            dis = i[0];
            drv(i < 5 ? 5'h01 << i : lf[4:0] | 5'h01, 3'h0, 1'b0, 1'b0);
            drv(5'h00, 3'h0, 1'b0, 1'b0);
            rdc(DSF_OFS_SUPPLY);
            rdc(DSF_OFS_SUPPLY);
            rdc(DSF_OFS_MAIN);
            repeat (SUP_RCV_CYC + 20) @(negedge clk);
            if (i == 2) rpt_pulse(1);
            rdc(DSF_OFS_SUPPLY);
            rdc(DSF_OFS_SUPPLY);
        end
        do_reset();
        @(negedge clk);
        chk("image", expv(DSF_OFS_MAIN), main_o);
        rpt_pulse(0);
        rdc(DSF_OFS_MAIN);
        @(negedge clk);
        dval = 1'b1;
        @(negedge clk);
        dval = 1'b0;
        m_init = 0;
        rdc(DSF_OFS_MAIN);
        complete_run();
    end
endmodule
